// file: design/llcma_pkg.sv
/*
 * llcma_pkg: shared constants and types of the link-layer to MAC adapter.
 * assumes: one clock domain, octet-wide streams, 64-bit individual addresses.
 */
`default_nettype none
package llcma_pkg;
	// address and frame layout
	localparam int ADDR_W = 64;
	localparam int ADDR_BYTES = 8;
	localparam int CTRL_BYTES = 1;
	localparam int HDR_LEN = CTRL_BYTES + 2 * ADDR_BYTES;
	localparam int FCS_BYTES = 2;
	localparam int DST_FIRST = 1;
	localparam int SRC_FIRST = DST_FIRST + ADDR_BYTES;
	// frame control octet: data frame, acknowledge request bit clear
	localparam logic [7:0] FRAME_CTRL = 8'h01;
	localparam int ACK_REQ_BIT = 5;
	// check field
	localparam int CRC_W = 16;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	// null value carried by all unused primitive fields
	localparam logic [7:0] NULL_FIELD = 8'h00;
	// transmit status codes
	typedef enum logic [1:0] {
		ST_SUCCESS,
		ST_TRANSMISSION_PENDING,
		ST_NO_BEACON,
		ST_CHANNEL_ACCESS_FAILURE
	} llcma_status_e;
endpackage
`default_nettype wire

// file: design/llcma_fifo.sv
/*
 * llcma_fifo: flip-flop FIFO with valid/ready on both sides.
 * assumes: single clock, asynchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module llcma_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] count;
	} llcma_fifo_s;

	llcma_fifo_s s_q, s_d;
	logic push, pop;

	// honest full and empty from the occupancy count
	assign inReady = (s_q.count != CW'(DEPTH));
	assign outValid = (s_q.count != '0);
	assign outData = s_q.mem[s_q.rd];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// next state: write, read and count update
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr] = inData;
			s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// file: design/llcma_adapter.sv
/*
 * llcma_adapter: convergence adapter between an upper link entity and the
 * MAC data service; builds and sends frames, reports status, checks and
 * delivers received frames.
 * assumes: external unslotted channel-access engine answers ccaReq with a
 * one-cycle ccaDone; receive bytes arrive only while rxReady is high.
 */
// Behaviour
// - request starts transmission without further command
// - frame built from addresses and payload
// - sent after channel access, no acknowledgment
// - busy channel reports channel access failure
// - sent frame reports success
// - status is one of four codes
// - status only after request, echoes addresses
// - unused primitive fields always null
// - addresses are individual 64-bit addresses
// - valid check sequence delivers payload of 1 to RX_DEPTH octets upward
// - invalid check sequence drops frame silently
// - check field is two octets
// - generator x16+x12+x5+1
// - remainder of shifted message is check
// - highest remainder coefficient sent first
// - first transmitted bit is highest degree
`timescale 1ns/10ps
`default_nettype none
module llcma_adapter #(
	parameter int FIFO_DEPTH = 8,
	parameter int RX_DEPTH = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [llcma_pkg::ADDR_W-1:0] reqSourceAddress,
	input wire logic [llcma_pkg::ADDR_W-1:0] reqDestinationAddress,
	input wire logic txDataValid,
	output logic txDataReady,
	input wire logic [7:0] txData,
	input wire logic txDataLast,
	output logic ccaReq,
	input wire logic ccaDone,
	input wire logic ccaBusy,
	output logic phyValid,
	input wire logic phyReady,
	output logic [7:0] phyData,
	output logic phyLast,
	output logic statusValid,
	output llcma_pkg::llcma_status_e statusCode,
	output logic [llcma_pkg::ADDR_W-1:0] statusSourceAddress,
	output logic [llcma_pkg::ADDR_W-1:0] statusDestinationAddress,
	output logic [7:0] providedPrecedenceField,
	output logic [7:0] providedClassField,
	input wire logic rxValid,
	output logic rxReady,
	input wire logic [7:0] rxData,
	input wire logic rxLast,
	output logic indValid,
	input wire logic indReady,
	output logic [7:0] indData,
	output logic indLast,
	output logic [llcma_pkg::ADDR_W-1:0] indSourceAddress,
	output logic [llcma_pkg::ADDR_W-1:0] indDestinationAddress,
	output logic [7:0] routeInfoField,
	output logic [7:0] receiveOutcomeField,
	output logic [7:0] classOfServiceField
);
	import llcma_pkg::*;

	localparam int BUF_N = RX_DEPTH + FCS_BYTES;
	localparam int RCW = $clog2(HDR_LEN + BUF_N + 1);
	localparam int BIW = $clog2(BUF_N);

	typedef enum logic [2:0] {TX_IDLE, TX_ACCESS, TX_HDR, TX_BODY, TX_FCS, TX_DRAIN,
		TX_REPORT} llcma_tx_e;
	typedef enum logic [1:0] {RX_COLLECT, RX_SKIP, RX_DELIVER} llcma_rx_e;

	typedef struct packed {
		llcma_tx_e tx;
		logic [4:0] txCnt;
		logic [ADDR_W-1:0] txSrc;
		logic [ADDR_W-1:0] txDst;
		logic [CRC_W-1:0] txCrc;
		llcma_status_e status;
		logic statusValid;
		llcma_rx_e rx;
		logic [RCW-1:0] rxCnt;
		logic [ADDR_W-1:0] rxSrc;
		logic [ADDR_W-1:0] rxDst;
		logic [CRC_W-1:0] rxCrc;
		logic [1:0][7:0] rxHold;
		logic [BUF_N-1:0][7:0] rxBuf;
		logic [RCW-1:0] rxLen;
		logic [RCW-1:0] rxOut;
	} llcma_state_s;

	llcma_state_s s_q, s_d;
	logic fifoOutValid, fifoOutReady, fifoLast;
	logic [7:0] fifoData;
	logic [CRC_W-1:0] rxCrcNext;
	logic rxCrcOk;

	////////////////////////////////////////////////////////////////////////////
	// check value arithmetic

	// one shift of the generator register
	function automatic logic [CRC_W-1:0] crcBit(input logic [CRC_W-1:0] c, input logic b);
		logic fb;
		fb = c[CRC_W-1] ^ b;
		crcBit = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
	endfunction

	// octet enters msb first, one serial step per bit
	function automatic logic [CRC_W-1:0] crcByte(input logic [CRC_W-1:0] c, input logic [7:0] d);
		logic [CRC_W-1:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = crcBit(r, d[i]);
		end
		crcByte = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// payload buffer between upper entity and frame sender

	llcma_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) llcma_fifo_i (
		.clk(clk),
		.resetn(resetn),
		.inValid(txDataValid),
		.inReady(txDataReady),
		.inData({txDataLast, txData}),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData({fifoLast, fifoData})
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// handshakes and frame byte selection
	always_comb begin
		reqReady = (s_q.tx == TX_IDLE);
		ccaReq = (s_q.tx == TX_ACCESS);
		fifoOutReady = (s_q.tx == TX_DRAIN) || ((s_q.tx == TX_BODY) && phyReady);
		phyValid = 1'b0;
		phyData = FRAME_CTRL;
		phyLast = 1'b0;
		case (s_q.tx)
			TX_HDR: begin
				phyValid = 1'b1;
				if (s_q.txCnt >= 5'(SRC_FIRST)) begin
					phyData = s_q.txSrc[ADDR_W-1 -: 8];
				end else if (s_q.txCnt >= 5'(DST_FIRST)) begin
					phyData = s_q.txDst[ADDR_W-1 -: 8];
				end
			end
			TX_BODY: begin
				phyValid = fifoOutValid;
				phyData = fifoData;
			end
			// high remainder octet first, then low
			TX_FCS: begin
				phyValid = 1'b1;
				phyData = (s_q.txCnt == 5'd0) ? s_q.txCrc[15:8] : s_q.txCrc[7:0];
				phyLast = (s_q.txCnt == 5'(FCS_BYTES - 1));
			end
			default: begin
				phyValid = 1'b0;
			end
		endcase
	end

	// status and echoed addresses come straight from registers
	assign statusValid = s_q.statusValid;
	assign statusCode = s_q.status;
	assign statusSourceAddress = s_q.txSrc;
	assign statusDestinationAddress = s_q.txDst;
	assign providedPrecedenceField = NULL_FIELD;
	assign providedClassField = NULL_FIELD;
	assign routeInfoField = NULL_FIELD;
	assign receiveOutcomeField = NULL_FIELD;
	assign classOfServiceField = NULL_FIELD;

	// delivery stream out of the receive buffer
	assign rxReady = (s_q.rx != RX_DELIVER);
	assign indValid = (s_q.rx == RX_DELIVER);
	assign indData = s_q.rxBuf[BIW'(s_q.rxOut)];
	assign indLast = indValid && (s_q.rxOut == s_q.rxLen - 1'b1);
	assign indSourceAddress = s_q.rxSrc;
	assign indDestinationAddress = s_q.rxDst;

	// recompute over all but last two octets, compare with them
	assign rxCrcNext = (s_q.rxCnt >= RCW'(2)) ? crcByte(s_q.rxCrc, s_q.rxHold[1]) : s_q.rxCrc;
	assign rxCrcOk = (rxCrcNext == {s_q.rxHold[0], rxData})
		&& (s_q.rxCnt >= RCW'(HDR_LEN + FCS_BYTES));

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		s_d.statusValid = 1'b0;
		case (s_q.tx)
			// accepted request moves directly to channel access
			TX_IDLE: begin
				if (reqValid) begin
					s_d.txSrc = reqSourceAddress;
					s_d.txDst = reqDestinationAddress;
					s_d.txCnt = '0;
					s_d.txCrc = CRC_INIT;
					s_d.tx = TX_ACCESS;
				end
			end
			// send only once the channel is granted
			TX_ACCESS: begin
				if (ccaDone && ccaBusy) begin
					// busy channel: drop payload, report failure
					s_d.status = ST_CHANNEL_ACCESS_FAILURE;
					s_d.tx = TX_DRAIN;
				end else if (ccaDone) begin
					s_d.tx = TX_HDR;
				end
			end
			TX_HDR: begin
				if (phyReady) begin
					s_d.txCrc = crcByte(s_q.txCrc, phyData);
					s_d.txCnt = s_q.txCnt + 1'b1;
					if (s_q.txCnt >= 5'(SRC_FIRST)) begin
						s_d.txSrc = {s_q.txSrc[ADDR_W-9:0], s_q.txSrc[ADDR_W-1 -: 8]};
					end else if (s_q.txCnt >= 5'(DST_FIRST)) begin
						s_d.txDst = {s_q.txDst[ADDR_W-9:0], s_q.txDst[ADDR_W-1 -: 8]};
					end
					if (s_q.txCnt == 5'(HDR_LEN - 1)) begin
						s_d.tx = TX_BODY;
					end
				end
			end
			TX_BODY: begin
				if (fifoOutValid && phyReady) begin
					s_d.txCrc = crcByte(s_q.txCrc, fifoData);
					if (fifoLast) begin
						s_d.txCnt = '0;
						s_d.tx = TX_FCS;
					end
				end
			end
			TX_FCS: begin
				if (phyReady) begin
					s_d.txCnt = s_q.txCnt + 1'b1;
					if (s_q.txCnt == 5'(FCS_BYTES - 1)) begin
						s_d.status = ST_SUCCESS;
						s_d.tx = TX_REPORT;
					end
				end
			end
			TX_DRAIN: begin
				if (fifoOutValid && fifoLast) begin
					s_d.tx = TX_REPORT;
				end
			end
			TX_REPORT: begin
				s_d.statusValid = 1'b1;
				s_d.tx = TX_IDLE;
			end
			default: begin
				s_d.tx = TX_IDLE;
			end
		endcase
		case (s_q.rx)
			RX_COLLECT: begin
				if (rxValid) begin
					s_d.rxCnt = s_q.rxCnt + 1'b1;
					s_d.rxCrc = (s_q.rxCnt == '0) ? CRC_INIT : rxCrcNext;
					s_d.rxHold = {s_q.rxHold[0], rxData};
					if (s_q.rxCnt >= RCW'(HDR_LEN)) begin
						s_d.rxBuf[BIW'(s_q.rxCnt - RCW'(HDR_LEN))] = rxData;
					end else if (s_q.rxCnt >= RCW'(SRC_FIRST)) begin
						s_d.rxSrc = {s_q.rxSrc[ADDR_W-9:0], rxData};
					end else if (s_q.rxCnt >= RCW'(DST_FIRST)) begin
						s_d.rxDst = {s_q.rxDst[ADDR_W-9:0], rxData};
					end
					if (rxLast) begin
						s_d.rxCnt = '0;
						// good check: deliver payload and addresses
						// bad check: drop without any indication
						if (rxCrcOk) begin
							s_d.rxLen = s_q.rxCnt - RCW'(HDR_LEN + FCS_BYTES - 1);
							s_d.rxOut = '0;
							s_d.rx = RX_DELIVER;
						end
					end else if (s_q.rxCnt == RCW'(HDR_LEN + BUF_N - 1)) begin
						s_d.rx = RX_SKIP;
					end
				end
			end
			RX_SKIP: begin
				if (rxValid && rxLast) begin
					s_d.rxCnt = '0;
					s_d.rx = RX_COLLECT;
				end
			end
			RX_DELIVER: begin
				if (indReady) begin
					s_d.rxOut = s_q.rxOut + 1'b1;
					if (indLast) begin
						s_d.rx = RX_COLLECT;
					end
				end
			end
			default: begin
				s_d.rx = RX_COLLECT;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic chkPending_q;
	logic [ADDR_W-1:0] chkSrc_q, chkDst_q;

	// reference copy of the request and an outstanding flag
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chkPending_q <= 1'b0;
			chkSrc_q <= '0;
			chkDst_q <= '0;
		end else if (reqValid && reqReady) begin
			chkPending_q <= 1'b1;
			chkSrc_q <= reqSourceAddress;
			chkDst_q <= reqDestinationAddress;
		end else if (statusValid) begin
			chkPending_q <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_req_starts_access: assert property (
		reqValid && reqReady |=> ccaReq) else $error("request did not start access");
	chk_busy_fail_code: assert property (
		ccaReq && ccaDone && ccaBusy |=> statusCode == ST_CHANNEL_ACCESS_FAILURE && !phyValid)
		else $error("busy channel not reported");
	chk_sent_success: assert property (
		phyValid && phyReady && phyLast |=> ##1 statusValid && statusCode == ST_SUCCESS)
		else $error("sent frame not reported as success");
	chk_status_echo: assert property (
		statusValid |-> chkPending_q && statusSourceAddress == chkSrc_q
		&& statusDestinationAddress == chkDst_q) else $error("status without request");
	chk_null_fields: assert property (
		(providedPrecedenceField | providedClassField | routeInfoField
		| receiveOutcomeField | classOfServiceField) == NULL_FIELD)
		else $error("unused field not null");
	chk_no_ack_req: assert property (
		phyValid && s_q.tx == TX_HDR && s_q.txCnt == 5'd0 |-> !phyData[ACK_REQ_BIT])
		else $error("frame requests acknowledgment");
	chk_fcs_high_first: assert property (
		phyValid && phyReady && s_q.tx == TX_FCS && !phyLast |=> phyLast
		&& phyData == $past(s_q.txCrc[7:0])) else $error("check octets out of order");
	chk_poly_vector: assert property (
		crcByte(CRC_INIT, 8'h01) == 16'h1021) else $error("wrong generator");
	chk_bad_fcs_drop: assert property (
		rxValid && rxLast && s_q.rx == RX_COLLECT && !rxCrcOk |=> (!indValid)[*2])
		else $error("bad frame indicated");
	chk_good_fcs_deliver: assert property (
		rxValid && rxLast && s_q.rx == RX_COLLECT && rxCrcOk |=> indValid
		&& indDestinationAddress == s_q.rxDst) else $error("good frame not delivered");

	cov_tx_success: cover property (statusValid && statusCode == ST_SUCCESS);
	cov_tx_fail: cover property (statusValid && statusCode == ST_CHANNEL_ACCESS_FAILURE);
	cov_rx_good: cover property (indValid && indReady && indLast);
	cov_rx_bad: cover property (rxValid && rxLast && s_q.rx == RX_COLLECT && !rxCrcOk);
endmodule
`default_nettype wire

// file: testbench/llcma_chan_model.sv
/*
 * llcma_chan_model: channel-access engine and frame sink on the far side.
 * assumes: the adapter holds ccaReq until the edge that carries ccaDone.
 */
`timescale 1ns/10ps
`default_nettype none
module llcma_chan_model (
	input wire logic clk,
	input wire logic busyMode,
	input wire logic [7:0] ccaDelay,
	input wire logic stallPhy,
	input wire logic ccaReq,
	output logic ccaDone,
	output logic ccaBusy,
	input wire logic phyValid,
	output logic phyReady,
	input wire logic [7:0] phyData,
	input wire logic phyLast
);
	logic [7:0] frameQ[$];
	int lastPos = -1;
	initial begin
		ccaDone = 1'b0;
		ccaBusy = 1'b1;
		phyReady = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// channel access: one done pulse per wait, busy flag valid only with it
	always begin
		@(negedge clk);
		if (ccaReq) begin
			repeat (ccaDelay) @(posedge clk);
			ccaDone <= 1'b1;
			ccaBusy <= busyMode;
			@(posedge clk);
			ccaDone <= 1'b0;
			ccaBusy <= ~busyMode;
		end
	end
	// sink: record each octet taken at the coming edge
	always @(negedge clk) begin
		if (phyValid && phyReady) begin
			frameQ.push_back(phyData);
			if (phyLast)
				lastPos = frameQ.size() - 1;
		end
	end
	// stalling sink accepts every other cycle
	always @(posedge clk) phyReady <= stallPhy ? ~phyReady : 1'b1;
endmodule
`default_nettype wire

// file: testbench/llcma_adapter_tb.sv
/*
 * llcma_adapter_tb: self-checking bench for the link-layer to MAC adapter.
 * assumes: channel model answers access requests; the bench plays the upper entity.
 */
`timescale 1ns/10ps
`default_nettype none
module llcma_adapter_tb;
	import llcma_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, reqValid = 1'b0, reqReady, txDataValid = 1'b0;
	logic [63:0] reqSourceAddress = '0, reqDestinationAddress = '0;
	logic txDataReady, txDataLast = 1'b0, ccaReq, ccaDone, ccaBusy, phyValid, phyReady, phyLast;
	logic [7:0] txData = 8'h00, phyData, indData, rxData = 8'h00, ccaDelay = 8'h0c;
	logic statusValid, rxValid = 1'b0, rxReady, rxLast = 1'b0, indValid, indReady = 1'b1;
	logic indLast, busyMode = 1'b0, stallPhy = 1'b0;
	llcma_status_e statusCode;
	logic [63:0] statusSourceAddress, statusDestinationAddress;
	logic [63:0] indSourceAddress, indDestinationAddress;
	logic [7:0] providedPrecedenceField, providedClassField;
	logic [7:0] routeInfoField, receiveOutcomeField, classOfServiceField;
	int miscompares = 0, checked = 0, cycles = 0, reqCount = 0, statusCount = 0;
	bit sawFull;

	llcma_adapter llcma_adapter_i (.clk, .resetn, .reqValid, .reqReady, .reqSourceAddress,
		.reqDestinationAddress, .txDataValid, .txDataReady, .txData, .txDataLast, .ccaReq,
		.ccaDone, .ccaBusy, .phyValid, .phyReady, .phyData, .phyLast, .statusValid,
		.statusCode, .statusSourceAddress, .statusDestinationAddress,
		.providedPrecedenceField, .providedClassField, .rxValid, .rxReady, .rxData, .rxLast,
		.indValid, .indReady, .indData, .indLast, .indSourceAddress, .indDestinationAddress,
		.routeInfoField, .receiveOutcomeField, .classOfServiceField);
	llcma_chan_model llcma_chan_model_i (.clk, .busyMode, .ccaDelay, .stallPhy, .ccaReq,
		.ccaDone, .ccaBusy, .phyValid, .phyReady, .phyData, .phyLast);

	////////////////////////////////////////////////////////////////
	// clock, watchdog and status counting
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			$display("[ERR] %0t run timed out", $time);
			summarize();
		end
	end
	always @(negedge clk) if (statusValid === 1'b1) statusCount++;

	////////////////////////////////////////////////////////////////
	// comparisons and verdict
	function automatic void bad(input string what);
		miscompares++;
		$display("[ERR] %0t %s", $time, what);
	endfunction
	function automatic void cmpByte(input logic [7:0] got, input logic [7:0] exp, input string w);
		checked++;
		if (got !== exp) bad($sformatf("%s got %h exp %h", w, got, exp));
	endfunction
	function automatic void cmpAddr(input logic [63:0] got, input logic [63:0] exp, input string w);
		checked++;
		if (got !== exp) bad($sformatf("%s got %h exp %h", w, got, exp));
	endfunction
	function automatic void cmpCode(input llcma_status_e got, input llcma_status_e exp);
		checked++;
		if (got !== exp) bad($sformatf("status got %0d exp %0d", got, exp));
	endfunction
	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// reference check value: divide shifted message, first bit highest degree
	function automatic logic [15:0] crcOf(input logic [7:0] q[$]);
		logic [15:0] c;
		logic fb;
		c = CRC_INIT;
		foreach (q[i]) begin
			for (int b = 7; b >= 0; b--) begin
				fb = c[15] ^ q[i][b];
				c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
			end
		end
		return c;
	endfunction
	// expected frame: control, destination, source, payload, check high then low
	function automatic void mkFrame(input logic [63:0] s, input logic [63:0] d,
		input logic [7:0] pl[$], output logic [7:0] f[$]);
		logic [15:0] c;
		f = {};
		f.push_back(FRAME_CTRL);
		for (int i = 7; i >= 0; i--) f.push_back(d[8*i+:8]);
		for (int i = 7; i >= 0; i--) f.push_back(s[8*i+:8]);
		foreach (pl[i]) f.push_back(pl[i]);
		c = crcOf(f);
		f.push_back(c[15:8]);
		f.push_back(c[7:0]);
	endfunction

	////////////////////////////////////////////////////////////////
	// transmit: request plus payload, then status and sent frame are judged
	task automatic txFrame(input logic [63:0] s, input logic [63:0] d, input int n, input bit busy);
		logic [7:0] pl[$];
		logic [7:0] f[$];
		for (int i = 0; i < n; i++) pl.push_back(8'(8'h30 + 7 * i));
		llcma_chan_model_i.frameQ.delete();
		llcma_chan_model_i.lastPos = -1;
		sawFull = 0;
		busyMode <= busy;
		stallPhy <= !busy;
		fork
			begin
				// individual addresses ride with the request
				@(posedge clk);
				reqValid <= 1'b1;
				reqSourceAddress <= s;
				reqDestinationAddress <= d;
				reqCount++;
				do @(negedge clk); while (reqReady !== 1'b1);
				@(posedge clk);
				reqValid <= 1'b0;
			end
			begin
				@(posedge clk);
				foreach (pl[i]) begin
					txDataValid <= 1'b1;
					txData <= pl[i];
					txDataLast <= (i == n - 1);
					do begin
						@(negedge clk);
						if (!txDataReady) sawFull = 1;
					end while (txDataReady !== 1'b1);
					@(posedge clk);
				end
				txDataValid <= 1'b0;
				txDataLast <= 1'b0;
			end
		join
		// nothing more is issued until the status arrives
		do @(negedge clk); while (statusValid !== 1'b1);
		cmpCode(statusCode, busy ? ST_CHANNEL_ACCESS_FAILURE : ST_SUCCESS);
		cmpAddr(statusSourceAddress, s, "status src");
		cmpAddr(statusDestinationAddress, d, "status dst");
		cmpByte(providedPrecedenceField, NULL_FIELD, "prov prec");
		cmpByte(providedClassField, NULL_FIELD, "prov class");
		if (n > 8) cmpByte(8'(sawFull), 8'h01, "fifo full");
		if (busy) begin
			cmpByte(8'(llcma_chan_model_i.frameQ.size()), 8'h00, "octets sent");
		end else begin
			mkFrame(s, d, pl, f);
			cmpByte(8'(llcma_chan_model_i.frameQ.size()), 8'(f.size()), "length");
			foreach (f[i]) cmpByte(llcma_chan_model_i.frameQ[i], f[i], "octet");
			cmpByte(llcma_chan_model_i.frameQ[0] & 8'h20, 8'h00, "ack bit");
			cmpByte(8'(llcma_chan_model_i.lastPos), 8'(f.size() - 1), "last");
		end
		$display("test tx n=%0d busy=%0d done", n, busy);
	endtask

	////////////////////////////////////////////////////////////////
	// receive: feed a frame, then judge what is delivered upward
	task automatic rxFrame(input logic [63:0] s, input logic [63:0] d, input int n, input bit corrupt);
		logic [7:0] pl[$];
		logic [7:0] f[$];
		int k;
		for (int i = 0; i < n; i++) pl.push_back(8'(8'h50 + i));
		mkFrame(s, d, pl, f);
		if (corrupt) f[f.size() - 1] ^= 8'h01;
		@(posedge clk);
		foreach (f[i]) begin
			rxValid <= 1'b1;
			rxData <= f[i];
			rxLast <= (i == f.size() - 1);
			do @(negedge clk); while (rxReady !== 1'b1);
			@(posedge clk);
		end
		rxValid <= 1'b0;
		rxLast <= 1'b0;
		k = 0;
		repeat (40) begin
			@(negedge clk);
			if (indValid !== 1'b0 && indReady) begin
				if (k == 0) begin
					cmpAddr(indSourceAddress, s, "ind src");
					cmpAddr(indDestinationAddress, d, "ind dst");
					cmpByte(routeInfoField, NULL_FIELD, "route");
					cmpByte(receiveOutcomeField, NULL_FIELD, "outcome");
					cmpByte(classOfServiceField, NULL_FIELD, "class");
				end
				if (k < n) cmpByte(indData, pl[k], "ind data");
				cmpByte(8'(indLast), 8'(k == n - 1), "ind last");
				k++;
			end
		end
		cmpByte(8'(k), corrupt ? 8'h00 : 8'(n), "delivered");
		$display("test rx corrupt=%0d done", corrupt);
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		txFrame(64'h0123_4567_89ab_cdef, 64'h0011_2233_4455_6677, 10, 1'b0);
		txFrame(64'h0a0b_0c0d_0e0f_1011, 64'hf0e0_d0c0_b0a0_9080, 3, 1'b1);
		txFrame(64'h8000_0000_0000_0001, 64'h0000_0000_0000_0002, 1, 1'b0);
		rxFrame(64'h1122_3344_5566_7788, 64'h99aa_bbcc_ddee_ff00, 4, 1'b0);
		rxFrame(64'h1122_3344_5566_7788, 64'h99aa_bbcc_ddee_ff00, 4, 1'b1);
		cmpByte(8'(statusCount), 8'(reqCount), "status count");
		summarize();
	end
endmodule
`default_nettype wire
